// File: logic/mac_client_params.svh
// constants for the mac client status and flow-control block
`ifndef MAC_CLIENT_PARAMS_SVH
`define MAC_CLIENT_PARAMS_SVH
`define POS_PFC        39
`define POS_UNICAST    38
`define POS_MULTICAST  37
`define POS_BROADCAST  36
`define POS_PAUSE      35
`define POS_CONTROL    34
`define POS_VLAN       33
`define POS_STACKED    32
`define POS_FLEN_LO    16
`define POS_ERR_PLEN   2
`define POS_ERR_OVER   1
`define INFO_W         40
`define ERR_W          7
`define QUEUE_MAX      8
`define DEF_QUEUES     1
`define CODE_IDLE      2'h0
`define CODE_XON       2'h1
`define CODE_XOFF      2'h2
`define MIN_PAYLOAD    16'h002E
`define TYPE_LEN_MAX   16'h05DC
`define TYPE_PAUSE     16'h8808
`define TYPE_VLAN      16'h8100
`define DEF_MAX_FRAME  16'h05EE
`define HDR_BYTES      16'h000E
`define FCS_BYTES      16'h0004
`define VLAN_BYTES     16'h0004
`endif

// File: logic/mac_client_pkg.sv
// types shared by the mac client status and flow-control block
package mac_client_pkg;
  typedef enum logic [1:0] {
    FLOW_NONE,
    FLOW_XON,
    FLOW_XOFF
  } flow_req_t;
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_BODY
  } tx_phase_t;
endpackage

// File: logic/flow_req_if.sv
// carrier of flow-control requests between decoder and main block
`timescale 1ns/10ps
`default_nettype none
interface flow_req_if #(parameter int Q = 1);
  logic [Q-1:0] xon;
  logic [Q-1:0] xoff;
  logic [Q-1:0] hold;
  modport src (output xon, output xoff, output hold);
  modport dst (input xon, input xoff, input hold);
endinterface
`default_nettype wire

// File: logic/flow_req_decode.sv
// per-queue decoder of flow-control request codes
`timescale 1ns/10ps
`default_nettype none
`include "mac_client_params.svh"
module flow_req_decode
  import mac_client_pkg::*;
#(
  parameter int Q = `DEF_QUEUES
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         two_bit,
  input  wire logic [Q-1:0] low_bits,
  input  wire logic [Q-1:0] high_bits,
  flow_req_if.src           req
);
  typedef struct packed {
    logic [Q-1:0] prev;
    logic [Q-1:0] xon;
    logic [Q-1:0] xoff;
    logic [Q-1:0] hold;
  } dec_state_t;
  dec_state_t s_q;
  dec_state_t s_d;
  logic [1:0] code;

  always_comb begin
    s_d      = s_q;
    code     = 2'h0;
    s_d.prev = low_bits;
    for (int i = 0; i < Q; i++) begin
      s_d.xon[i]  = 1'b0;
      s_d.xoff[i] = 1'b0;
      s_d.hold[i] = 1'b0;
      if (two_bit) begin
        code = {high_bits[i], low_bits[i]};
        unique case (code)
          `CODE_XON:  s_d.xon[i]  = 1'b1;
          `CODE_XOFF: s_d.xoff[i] = 1'b1;
          `CODE_IDLE: s_d.hold[i] = 1'b1;
          default:    s_d.hold[i] = 1'b1;
        endcase
      end else begin
        // high vector unused here
        s_d.xoff[i] = low_bits[i] & ~s_q.prev[i];
        s_d.xon[i]  = ~low_bits[i] & s_q.prev[i];
        s_d.hold[i] = low_bits[i] & s_q.prev[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign req.xon  = s_q.xon;
  assign req.xoff = s_q.xoff;
  assign req.hold = s_q.hold;
endmodule
`default_nettype wire

// File: logic/mac_client_status_flow_ctrl.sv
// client-side tx status, flow-control requests and rx word ordering
`timescale 1ns/10ps
`default_nettype none
`include "mac_client_params.svh"
module mac_client_status_flow_ctrl
  import mac_client_pkg::*;
#(
  parameter int Q = `DEF_QUEUES
) (
  input  wire logic                 I_CLK,
  input  wire logic                 I_RESETN,
  input  wire logic                 I_TX_VALID,
  input  wire logic                 I_TX_SOP,
  input  wire logic                 I_TX_EOP,
  input  wire logic [2:0]           I_TX_EMPTY,
  input  wire logic [63:0]          I_TX_CLIENT_WORD,
  input  wire logic [15:0]          I_MAX_FRAME,
  input  wire logic                 I_FLOW_TWO_BIT,
  input  wire logic [Q-1:0]         I_FLOW_REQ_LOW_BITS,
  input  wire logic [Q-1:0]         I_FLOW_REQ_HIGH_BITS,
  input  wire logic                 I_RX_VALID,
  input  wire logic [63:0]          I_RX_LINE_WORD,
  output logic [`INFO_W-1:0]        O_TX_FRAME_INFO_WORD,
  output logic [`ERR_W-1:0]         O_TX_FRAME_ERROR_FLAGS,
  output logic                      O_TX_FRAME_INFO_STROBE,
  output logic [Q-1:0]              O_FLOW_XON,
  output logic [Q-1:0]              O_FLOW_XOFF,
  output logic [Q-1:0]              O_FLOW_ACTIVE,
  output logic                      O_RX_VALID,
  output logic [63:0]               O_RX_CLIENT_WORD
);
  typedef struct packed {
    tx_phase_t          phase;
    logic [2:0]         word_idx;
    logic [15:0]        bytes;
    logic [15:0]        type_len;
    logic [7:0]         kind;
    logic               tag_seen;
    logic               stacked;
    logic [`INFO_W-1:0] info;
    logic [`ERR_W-1:0]  err;
    logic               strobe;
    logic [Q-1:0]       xon;
    logic [Q-1:0]       xoff;
    logic [Q-1:0]       active;
    logic               rx_valid;
    logic [63:0]        rx_word;
  } top_state_t;
  top_state_t s_q;
  top_state_t s_d;
  logic [1:0] rst_sync_q;
  logic       rst_n;
  flow_req_if #(.Q(Q)) freq ();

  function automatic logic [63:0] swap_bytes(input logic [63:0] w);
    logic [63:0] r;
    r = '0;
    for (int b = 0; b < 8; b++) begin
      r[8*b +: 8] = w[8*(7-b) +: 8];
    end
    return r;
  endfunction

  // destination class from the six address bytes, group bit from the first
  function automatic logic [7:0] dest_kind(input logic [63:0] w);
    logic [7:0] k;
    k = '0;
    if (w[63:16] == 48'hFFFF_FFFF_FFFF) begin
      k[`POS_BROADCAST-32] = 1'b1;
    end else if (w[56]) begin
      k[`POS_MULTICAST-32] = 1'b1;
    end else begin
      k[`POS_UNICAST-32] = 1'b1;
    end
    return k;
  endfunction

  // header bytes ahead of the payload, four more per tag
  function automatic logic [15:0] head_bytes(input logic tag,
                                             input logic stacked);
    logic [15:0] h;
    h = `HDR_BYTES;
    if (tag) begin
      h = h + `VLAN_BYTES;
    end
    if (stacked) begin
      h = h + `VLAN_BYTES;
    end
    return h;
  endfunction

  function automatic logic [15:0] word_bytes(input logic [2:0] empty);
    return 16'h0008 - {13'h0, empty};
  endfunction

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  flow_req_decode #(.Q(Q)) u_dec (
    .clk       (I_CLK),
    .rst_n     (rst_n),
    .two_bit   (I_FLOW_TWO_BIT),
    .low_bits  (I_FLOW_REQ_LOW_BITS),
    .high_bits (I_FLOW_REQ_HIGH_BITS),
    .req       (freq.src)
  );

  always_comb begin
    logic [15:0] flen;
    logic [15:0] plen;
    logic [15:0] hdr;
    logic [15:0] tl;
    logic [7:0]  knd;
    logic [63:0] w;
    flen = '0;
    plen = '0;
    hdr  = '0;
    tl   = '0;
    knd  = '0;
    w    = I_TX_CLIENT_WORD;
    s_d  = s_q;
    s_d.strobe = 1'b0;
    // frame parse; first address byte in w[63:56]
    if (I_TX_VALID) begin
      if (I_TX_SOP && !I_TX_EOP) begin
        s_d.phase    = TX_BODY;
        s_d.word_idx = 3'h1;
        s_d.bytes    = 16'h0008;
        s_d.kind     = dest_kind(w);
        s_d.tag_seen = 1'b0;
        s_d.stacked  = 1'b0;
      // a word with both start and end is dropped, frame goes on
      end else if (s_q.phase == TX_BODY && !I_TX_SOP) begin
        if (s_q.word_idx == 3'h1) begin
          tl = w[31:16];
          knd = s_q.kind;
          if (tl == `TYPE_VLAN) begin
            knd[`POS_VLAN-32] = 1'b1;
            s_d.tag_seen = 1'b1;
          end
          if (tl == `TYPE_PAUSE) begin
            knd[`POS_CONTROL-32] = 1'b1;
            if (w[15:0] == 16'h0001) begin
              knd[`POS_PAUSE-32] = 1'b1;
            end else if (w[15:0] == 16'h0101) begin
              knd[`POS_PFC-32] = 1'b1;
            end
          end
          s_d.kind     = knd;
          s_d.type_len = tl;
        end
        if (s_q.word_idx == 3'h2 && s_q.tag_seen) begin
          s_d.type_len = w[63:48];
          // second tag: the length or type field moves four bytes on
          if (w[63:48] == `TYPE_VLAN) begin
            s_d.kind[`POS_STACKED-32] = 1'b1;
            s_d.stacked  = 1'b1;
            s_d.type_len = w[31:16];
          end
        end
        if (s_q.word_idx != 3'h7) begin
          s_d.word_idx = s_q.word_idx + 3'h1;
        end
        if (I_TX_EOP) begin
          flen = s_q.bytes + word_bytes(I_TX_EMPTY);
          hdr  = head_bytes(s_d.tag_seen, s_d.stacked);
          plen = flen - hdr - `FCS_BYTES;
          // word and flags then hold until the next strobe
          s_d.info = '0;
          s_d.info[`INFO_W-1:32] = s_d.kind;
          s_d.info[31:`POS_FLEN_LO] = flen;
          s_d.info[15:0] = plen;
          s_d.err = '0;
          if (s_d.type_len <= `TYPE_LEN_MAX &&
              s_d.type_len > plen) begin
            s_d.err[`POS_ERR_PLEN] = 1'b1;
          end
          if (flen > I_MAX_FRAME) begin
            s_d.err[`POS_ERR_OVER] = 1'b1;
          end
          s_d.strobe = 1'b1;
          s_d.phase  = TX_IDLE;
        end else begin
          s_d.bytes = s_q.bytes + 16'h0008;
        end
      end
    end
    // active: queue paused, or a request left to finish
    s_d.xon    = freq.xon;
    s_d.xoff   = freq.xoff;
    s_d.active = freq.hold | freq.xoff;
    // receive: one word a cycle, earliest byte moved to top lane
    s_d.rx_valid = I_RX_VALID;
    if (I_RX_VALID) begin
      s_d.rx_word = swap_bytes(I_RX_LINE_WORD);
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign O_TX_FRAME_INFO_WORD   = s_q.info;
  assign O_TX_FRAME_ERROR_FLAGS = s_q.err;
  assign O_TX_FRAME_INFO_STROBE = s_q.strobe;
  assign O_FLOW_XON             = s_q.xon;
  assign O_FLOW_XOFF            = s_q.xoff;
  assign O_FLOW_ACTIVE          = s_q.active;
  assign O_RX_VALID             = s_q.rx_valid;
  assign O_RX_CLIENT_WORD       = s_q.rx_word;
endmodule
`default_nettype wire

// File: verif/mac_client_status_flow_ctrl_properties.sv
// port assertions for the mac client block
`timescale 1ns/10ps
`default_nettype none
module mac_client_props #(parameter int Q = 1) (
  input wire logic         I_CLK,
  input wire logic         I_RESETN,
  input wire logic         I_TX_VALID,
  input wire logic         I_TX_SOP,
  input wire logic         I_TX_EOP,
  input wire logic         I_FLOW_TWO_BIT,
  input wire logic [Q-1:0] I_FLOW_REQ_LOW_BITS,
  input wire logic [Q-1:0] I_FLOW_REQ_HIGH_BITS,
  input wire logic         I_RX_VALID,
  input wire logic [63:0]  I_RX_LINE_WORD,
  input wire logic [6:0]   O_TX_FRAME_ERROR_FLAGS,
  input wire logic         O_TX_FRAME_INFO_STROBE,
  input wire logic [Q-1:0] O_FLOW_XON,
  input wire logic [Q-1:0] O_FLOW_XOFF,
  input wire logic [63:0]  O_RX_CLIENT_WORD
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  AST_STROBE_AT_EOP: assert property (
    I_TX_VALID && I_TX_EOP && !I_TX_SOP |=> O_TX_FRAME_INFO_STROBE)
    else $error("no strobe after frame end");
  AST_STROBE_CAUSE: assert property (
    O_TX_FRAME_INFO_STROBE |-> $past(I_TX_VALID && I_TX_EOP))
    else $error("strobe without frame end");
  AST_ERR_RSVD: assert property (
    O_TX_FRAME_INFO_STROBE |-> (O_TX_FRAME_ERROR_FLAGS & 7'h79) == 7'h00)
    else $error("reserved error bit set");
  AST_RX_LANES: assert property (
    I_RX_VALID |=> O_RX_CLIENT_WORD[63:56] == $past(I_RX_LINE_WORD[7:0])
    && O_RX_CLIENT_WORD[7:0] == $past(I_RX_LINE_WORD[63:56]))
    else $error("rx byte order wrong");
  AST_XOFF_ON_RISE: assert property (
    !I_FLOW_TWO_BIT && $rose(I_FLOW_REQ_LOW_BITS[0])
    |-> ##[1:2] O_FLOW_XOFF[0]) else $error("no xoff after rise");
  AST_XON_ON_FALL: assert property (
    !I_FLOW_TWO_BIT && $fell(I_FLOW_REQ_LOW_BITS[0]) |-> ##[1:2] O_FLOW_XON[0])
    else $error("no xon after fall");
  AST_HIGH_IGNORED: assert property (
    (!I_FLOW_TWO_BIT && !I_FLOW_REQ_LOW_BITS[0] && I_FLOW_REQ_HIGH_BITS[0])
    [*4] |-> !O_FLOW_XOFF[0] && !O_FLOW_XON[0]) else $error("stray request");
  AST_TWO_BIT_XOFF: assert property (
    (I_FLOW_TWO_BIT && I_FLOW_REQ_HIGH_BITS[0] && !I_FLOW_REQ_LOW_BITS[0]) [*3]
    |-> O_FLOW_XOFF[0] && !O_FLOW_XON[0]) else $error("code 10 not xoff");
  AST_TWO_BIT_XON: assert property (
    (I_FLOW_TWO_BIT && !I_FLOW_REQ_HIGH_BITS[0] && I_FLOW_REQ_LOW_BITS[0]) [*3]
    |-> O_FLOW_XON[0] && !O_FLOW_XOFF[0]) else $error("code 01 not xon");
  COV_STROBE: cover property (O_TX_FRAME_INFO_STROBE);
  COV_XON: cover property (O_FLOW_XON[0]);
  COV_XOFF: cover property (O_FLOW_XOFF[0]);
endmodule
bind mac_client_status_flow_ctrl mac_client_props #(.Q(Q)) u_props (
  .I_CLK                  (I_CLK),
  .I_RESETN               (I_RESETN),
  .I_TX_VALID             (I_TX_VALID),
  .I_TX_SOP               (I_TX_SOP),
  .I_TX_EOP               (I_TX_EOP),
  .I_FLOW_TWO_BIT         (I_FLOW_TWO_BIT),
  .I_FLOW_REQ_LOW_BITS    (I_FLOW_REQ_LOW_BITS),
  .I_FLOW_REQ_HIGH_BITS   (I_FLOW_REQ_HIGH_BITS),
  .I_RX_VALID             (I_RX_VALID),
  .I_RX_LINE_WORD         (I_RX_LINE_WORD),
  .O_TX_FRAME_ERROR_FLAGS (O_TX_FRAME_ERROR_FLAGS),
  .O_TX_FRAME_INFO_STROBE (O_TX_FRAME_INFO_STROBE),
  .O_FLOW_XON             (O_FLOW_XON),
  .O_FLOW_XOFF            (O_FLOW_XOFF),
  .O_RX_CLIENT_WORD       (O_RX_CLIENT_WORD)
);
`default_nettype wire

// File: verif/client_fabric_model.sv
// client fabric model streaming tx frames
`timescale 1ns/10ps
`default_nettype none
module client_fabric_model (
  input  wire logic        clk,
  output logic             valid,
  output logic             sop,
  output logic             eop,
  output logic [2:0]       empty,
  output logic [63:0]      word
);
  initial {valid, sop, eop, empty, word} = '0;
  task automatic send(input logic [7:0] da, input logic [15:0] ty, inr,
                      input logic [2:0] e);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {valid, sop, eop, empty} <= {1'b1, i == 0, i == 7, i == 7 ? e : 3'h0};
      word <= i == 0 ? {{6{da}}, 16'h0A0B}
            : i == 1 ? {32'h0, ty, (ty == 16'h8808 ? inr : 16'h0001)}
            : i == 2 ? {inr, 48'h0} : 64'(i);
    end
  endtask
  task automatic idle();
    @(posedge clk);
    {valid, sop, eop} <= 3'h0;
    word <= ~word;
  endtask
endmodule
`default_nettype wire

// File: verif/mac_client_status_flow_ctrl_tb_top.sv
// testbench for the mac client status and flow-control block
`timescale 1ns/10ps
`default_nettype none
module mac_client_status_flow_ctrl_tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, two = 1'b0, lo = 1'b0, hi = 1'b0;
  logic        rxv = 1'b0, tv, ts, te, stb, orv;
  logic [0:0]  xon, xoff, act;
  logic [2:0]  tem;
  logic [6:0]  err;
  logic [39:0] info;
  logic [63:0] tw, orw, rxw = 64'h0;
  int          fail_count = 0, checks = 0, cyc = 0;
  logic [7:0]  r_da [6] = '{8'h02, 8'hFF, 8'h01, 8'h04, 8'h01, 8'h06};
  logic [15:0] r_ty [6] = '{16'h002C, 16'h0030, 16'h8808, 16'h8100,
                            16'h8808, 16'h8100};
  logic [15:0] r_in [6] = '{16'h0000, 16'h0000, 16'h0001, 16'h002A,
                            16'h0101, 16'h8100};
  logic [2:0]  r_e  [6] = '{3'h2, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  logic [7:0]  r_fl [6] = '{8'h40, 8'h10, 8'h2C, 8'h42, 8'hA4, 8'h43};
  logic [6:0]  r_er [6] = '{7'h00, 7'h06, 7'h02, 7'h02, 7'h02, 7'h02};
  always #2 clk = ~clk;
  mac_client_status_flow_ctrl u_dut (.I_CLK(clk), .I_RESETN(rst_n),
    .I_TX_VALID(tv), .I_TX_SOP(ts), .I_TX_EOP(te), .I_TX_EMPTY(tem),
    .I_TX_CLIENT_WORD(tw), .I_MAX_FRAME(16'h003F), .I_FLOW_TWO_BIT(two),
    .I_FLOW_REQ_LOW_BITS(lo), .I_FLOW_REQ_HIGH_BITS(hi), .I_RX_VALID(rxv),
    .I_RX_LINE_WORD(rxw), .O_TX_FRAME_INFO_WORD(info),
    .O_TX_FRAME_ERROR_FLAGS(err), .O_TX_FRAME_INFO_STROBE(stb),
    .O_FLOW_XON(xon), .O_FLOW_XOFF(xoff), .O_FLOW_ACTIVE(act),
    .O_RX_VALID(orv), .O_RX_CLIENT_WORD(orw));
  client_fabric_model u_cli (.clk(clk), .valid(tv), .sop(ts), .eop(te),
    .empty(tem), .word(tw));
  task automatic chk(input string n, input logic [63:0] s, e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic t_tx();
    fork
      begin
        foreach (r_da[i]) u_cli.send(r_da[i], r_ty[i], r_in[i], r_e[i]);
        u_cli.idle();
      end
      foreach (r_da[i]) begin
        repeat (20) if (stb !== 1'b1) @(negedge clk);
        chk("strobe", 64'(stb), 64'h1);
        chk("type", 64'(info[39:32]), 64'(r_fl[i]));
        chk("flen", 64'(info[31:16]), 64'(64 - r_e[i]));
        chk("plen", 64'(info[15:0]), 64'(46 - r_e[i]
            - 4 * (r_ty[i] == 16'h8100) - 4 * (r_in[i] == 16'h8100)));
        chk("err", 64'(err), 64'(r_er[i]));
        @(negedge clk);
        chk("pulse", 64'(stb), 64'h0);
      end
    join
  endtask
  task automatic t_rx();
    @(posedge clk);
    {rxv, rxw} <= {1'b1, 64'h0102030405060708};
    @(posedge clk);
    {rxv, rxw} <= {1'b0, 64'hFEFDFCFBFAF9F8F7};
    @(negedge clk);
    chk("rxv", 64'(orv), 64'h1);
    chk("rxw", orw, 64'h0807060504030201);
  endtask
  task automatic count(output int a, b);
    {a, b} = '0;
    repeat (6) begin
      @(negedge clk);
      a += (xon === 1'b1);
      b += (xoff === 1'b1);
    end
  endtask
  task automatic t_flow1();
    int a, b;
    @(posedge clk);
    lo <= 1'b1;
    count(a, b);
    chk("xoff1", 64'(b + 8 * a), 64'h1);
    chk("act1", 64'(act), 64'h1);
    @(posedge clk);
    hi <= 1'b1;
    count(a, b);
    chk("hiign", 64'(a + b), 64'h0);
    @(posedge clk);
    lo <= 1'b0;
    count(a, b);
    chk("xon1", 64'(a + 8 * b), 64'h1);
  endtask
  task automatic t_flow2();
    logic [1:0] cd [3] = '{2'h2, 2'h1, 2'h0};
    @(posedge clk);
    {two, hi} <= 2'h2;
    foreach (cd[i]) begin
      @(posedge clk);
      {hi, lo} <= cd[i];
      repeat (4) @(negedge clk);
      chk("xoff2", 64'(xoff), 64'(cd[i] == 2'h2));
      chk("xon2", 64'(xon), 64'(cd[i] == 2'h1));
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk);
    chk("rst", 64'(stb), 64'h0);
    t_tx();
    t_rx();
    t_flow1();
    t_flow2();
    end_of_test();
  end
endmodule
`default_nettype wire
